// ===== include/pfa_cfg.svh
`ifndef PFA_CFG_SVH
`define PFA_CFG_SVH
`define PFA_WORD_W 14
`define PFA_ROW_WORDS 64
`define PFA_ROW_BITS 6
`define PFA_EE_DEPTH 256
`define PFA_UID_WORDS 4
`define PFA_ERASED_WORD 14'h3fff
`define PFA_ERASED_BYTE 8'hff
`define PFA_CFG_ERASED 4'hf
`define PFA_CFG_ADDR 3'h4
`define PFA_CP_BIT 0
`define PFA_CPD_BIT 1
`define PFA_WRT_LSB 2
`define PFA_WRT_ALL 2'h0
`define PFA_WRT_HALF 2'h1
`define PFA_WRT_QUARTER 2'h2
`define PFA_WRT_OFF 2'h3
`define PFA_KEY_FIRST 8'h55
`define PFA_KEY_SECOND 8'haa
`define PFA_PROG_TIME_NS 2000
`define PFA_CLK_PERIOD_NS 4
`endif

// ===== include/pfa_pkg.sv
package pfa_pkg;
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} pfa_state_t;
    typedef enum logic [1:0] {PGM_READ = 2'h0, PGM_WRITE = 2'h1, PGM_BULK = 2'h2} pfa_pgm_op_t;
    typedef enum logic [1:0] {SP_FLASH = 2'h0, SP_EEPROM = 2'h1, SP_CONFIG = 2'h2} pfa_space_t;
    typedef enum logic [1:0] {KEY_NONE = 2'h0, KEY_ONE = 2'h1, KEY_TWO = 2'h2} pfa_key_t;
endpackage

// ===== verilog/pfa_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfa_cfg.svh"

// What this block does
// - Internal timer times every self write and erase.
// - Code protection refuses programmer reads and writes.
// - Self write still works under code protection.
// - Only programmer bulk erase clears everything, protection included.
// - Self write protect field blocks a flash region.
// - Programmer ignores self write protection entirely.
// - Flash words are fourteen bits wide, plus extra words.
// - Fetch and pointer paths only read flash.
// - Every flash read returns exactly one word.
// - Erase sets ones, flash programming only clears bits; EEPROM writes overwrite the byte.
// - Rows of 64 words, smallest erasable unit.
// - Hidden latches loaded from the data pair.
// - Row program updates all or some words.
// - Erased words programmable without erase, others untouched.
// - Read start clears itself, data valid next cycle.
module pfa_ctrl
    import pfa_pkg::*;
#(
    parameter int AW = 13,
    parameter int PROG_TIME_NS = `PFA_PROG_TIME_NS
)(
    input wire logic SYS_CLK,                        // System clock.
    input wire logic SYS_RST,                        // Synchronous reset, active high.
    input wire logic [AW-1:0] FETCH_ADDR,            // Instruction fetch address.
    output logic [`PFA_WORD_W-1:0] FETCH_DATA,       // Fetched word, one cycle later.
    input wire logic PTR_RD,                         // Indirect pointer read strobe.
    input wire logic [AW-1:0] PTR_ADDR,              // Indirect pointer address.
    output logic [`PFA_WORD_W-1:0] PTR_DATA,         // Indirect read word.
    output logic PTR_VALID,                          // Indirect read word valid pulse.
    input wire logic [AW-1:0] NV_ADDR,               // Register interface address.
    input wire logic NV_DATA_HIGH_WE,                // Write strobe for nv_data_high.
    input wire logic NV_DATA_LOW_WE,                 // Write strobe for nv_data_low.
    input wire logic [7:0] NV_WDATA,                 // Write data for the data pair.
    output logic [5:0] NV_DATA_HIGH,                 // Data pair, upper six bits.
    output logic [7:0] NV_DATA_LOW,                  // Data pair, lower eight bits.
    input wire logic UNLOCK_WE,                      // Write strobe for unlock_key_reg.
    input wire logic [7:0] UNLOCK_WDATA,             // Key value written.
    input wire logic RD_SET,                         // Set the read start bit.
    input wire logic WR_SET,                         // Set the write start bit.
    input wire logic WR_ENABLE,                      // Write enable bit.
    input wire logic ERASE_SEL,                      // Row erase select bit.
    input wire logic LATCH_ONLY,                     // Load latch without commit.
    output logic RD_BUSY,                            // Read start bit.
    output logic WR_BUSY,                            // Write start bit, timed operation.
    output logic WR_ERROR,                           // Last write start was refused.
    output logic WR_DONE,                            // Write or load finished pulse.
    input wire logic PGM_REQ,                        // Programmer request strobe.
    input wire pfa_pgm_op_t PGM_OP,                  // Programmer operation.
    input wire pfa_space_t PGM_SPACE,                // Programmer target space.
    input wire logic [AW-1:0] PGM_ADDR,              // Programmer address.
    input wire logic [`PFA_WORD_W-1:0] PGM_WDATA,    // Programmer write data.
    output logic [`PFA_WORD_W-1:0] PGM_RDATA,        // Programmer read data.
    output logic PGM_ACK,                            // Request served pulse.
    output logic PGM_REFUSED                         // Request refused pulse.
);
    localparam int DEPTH = 1 << AW;
    localparam int PROG_CYCLES_I = (PROG_TIME_NS + `PFA_CLK_PERIOD_NS - 1) / `PFA_CLK_PERIOD_NS;
    localparam logic [15:0] PROG_CYCLES = 16'(PROG_CYCLES_I);
    localparam int RW = `PFA_ROW_WORDS;

    // Nonvolatile storage is not touched by the reset; only latch_vld_r clears.
    logic [`PFA_WORD_W-1:0] flash_mem [DEPTH];
    logic [7:0] ee_mem [`PFA_EE_DEPTH];
    logic [`PFA_WORD_W-1:0] uid_mem [`PFA_UID_WORDS];
    logic [3:0] cfg_r;
    logic [`PFA_WORD_W-1:0] latch_mem [RW];
    logic [RW-1:0] latch_vld_r;

    function automatic logic wrt_hit(input logic [1:0] f, input logic [AW-1:0] a);
        logic hit;
        hit = 1'b0;
        unique case (f)
            `PFA_WRT_ALL: hit = 1'b1;
            `PFA_WRT_HALF: hit = ~a[AW-1];
            `PFA_WRT_QUARTER: hit = (a[AW-1:AW-2] == 2'h0);
            `PFA_WRT_OFF: hit = 1'b0;
        endcase
        return hit;
    endfunction

    pfa_state_t state_r, state_nxt;
    pfa_key_t key_r, key_nxt;
    logic [15:0] timer_r, timer_nxt;
    logic [AW-1:0] op_addr_r, op_addr_nxt;
    logic op_erase_r, op_erase_nxt;
    logic err_r, err_nxt, done_r, done_nxt, rd_r, rd_nxt;
    logic [5:0] hi_r, hi_nxt;
    logic [7:0] lo_r, lo_nxt;
    logic [`PFA_WORD_W-1:0] fetch_r, fetch_nxt, ptr_r, ptr_nxt, prd_r, prd_nxt;
    logic pvld_r, pvld_nxt, ack_r, ack_nxt, ref_r, ref_nxt;
    logic wr_go, wr_prot, fin, cp_on, cpd_on, pgm_ok;
    logic lat_we, lat_clr, row_erase, row_commit, fl_we, ee_we, uid_we, cfg_we, bulk;
    logic [`PFA_WORD_W-1:0] fl_wdata;

    always_comb
    begin
        cp_on = ~cfg_r[`PFA_CP_BIT];
        cpd_on = ~cfg_r[`PFA_CPD_BIT];
        wr_go = WR_SET && WR_ENABLE && key_r == KEY_TWO && state_r == ST_IDLE;
        wr_prot = wrt_hit(cfg_r[`PFA_WRT_LSB+1:`PFA_WRT_LSB], NV_ADDR);
        fin = state_r == ST_BUSY && timer_r == 16'h0;
        state_nxt = state_r;
        timer_nxt = timer_r;
        op_addr_nxt = op_addr_r;
        op_erase_nxt = op_erase_r;
        err_nxt = err_r;
        done_nxt = 1'b0;
        rd_nxt = 1'b0;
        hi_nxt = hi_r;
        lo_nxt = lo_r;
        lat_we = 1'b0;
        row_erase = 1'b0;
        row_commit = 1'b0;
        lat_clr = 1'b0;
        // Any unrelated access between the keys breaks the unlock.
        if (UNLOCK_WE)
        begin
            if (UNLOCK_WDATA == `PFA_KEY_FIRST)
                key_nxt = KEY_ONE;
            else if (UNLOCK_WDATA == `PFA_KEY_SECOND && key_r == KEY_ONE)
                key_nxt = KEY_TWO;
            else
                key_nxt = KEY_NONE;
        end
        else if (NV_DATA_HIGH_WE || NV_DATA_LOW_WE || RD_SET || WR_SET)
            key_nxt = KEY_NONE;
        else
            key_nxt = key_r;
        if (NV_DATA_HIGH_WE)
            hi_nxt = NV_WDATA[5:0];
        if (NV_DATA_LOW_WE)
            lo_nxt = NV_WDATA;
        if (RD_SET && state_r == ST_IDLE)
        begin
            rd_nxt = 1'b1;
            op_addr_nxt = NV_ADDR;
        end
        if (rd_r)
            {hi_nxt, lo_nxt} = flash_mem[op_addr_r];
        if (WR_SET && state_r == ST_IDLE)
        begin
            err_nxt = !wr_go || wr_prot;
            if (wr_go && wr_prot)
                done_nxt = 1'b1;
            else if (wr_go && !ERASE_SEL)
                lat_we = 1'b1;
            if (wr_go && !wr_prot && (ERASE_SEL || !LATCH_ONLY))
            begin
                state_nxt = ST_BUSY;
                timer_nxt = PROG_CYCLES - 16'h1;
                op_addr_nxt = NV_ADDR;
                op_erase_nxt = ERASE_SEL;
            end
            else if (wr_go && !wr_prot)
                done_nxt = 1'b1;
        end
        if (state_r == ST_BUSY)
            timer_nxt = timer_r - 16'h1;
        if (fin)
        begin
            state_nxt = ST_IDLE;
            done_nxt = 1'b1;
            row_erase = op_erase_r;
            row_commit = !op_erase_r;
            lat_clr = !op_erase_r;
        end
        fetch_nxt = flash_mem[FETCH_ADDR];
        ptr_nxt = PTR_RD ? flash_mem[PTR_ADDR] : ptr_r;
        pvld_nxt = PTR_RD;
    end

    always_comb
    begin
        pgm_ok = 1'b1;
        unique case (PGM_SPACE)
            SP_FLASH: pgm_ok = !cp_on;
            SP_EEPROM: pgm_ok = !cpd_on;
            default: pgm_ok = 1'b1;
        endcase
        prd_nxt = prd_r;
        ack_nxt = 1'b0;
        ref_nxt = 1'b0;
        fl_we = 1'b0;
        ee_we = 1'b0;
        uid_we = 1'b0;
        cfg_we = 1'b0;
        bulk = 1'b0;
        fl_wdata = flash_mem[PGM_ADDR] & PGM_WDATA;
        if (PGM_REQ && state_r != ST_IDLE)
            ref_nxt = 1'b1;
        else if (PGM_REQ && PGM_OP == PGM_BULK)
        begin
            bulk = 1'b1;
            ack_nxt = 1'b1;
        end
        else if (PGM_REQ && !pgm_ok)
            ref_nxt = 1'b1;
        else if (PGM_REQ)
        begin
            // Self write protection is deliberately not consulted here.
            ack_nxt = 1'b1;
            if (PGM_OP == PGM_READ)
            begin
                unique case (PGM_SPACE)
                    SP_FLASH: prd_nxt = flash_mem[PGM_ADDR];
                    SP_EEPROM: prd_nxt = {6'h0, ee_mem[PGM_ADDR[7:0]]};
                    default: prd_nxt = (PGM_ADDR[2:0] == `PFA_CFG_ADDR) ? {10'h0, cfg_r}
                        : uid_mem[PGM_ADDR[1:0]];
                endcase
            end
            else
            begin
                fl_we = PGM_SPACE == SP_FLASH;
                ee_we = PGM_SPACE == SP_EEPROM;
                cfg_we = PGM_SPACE == SP_CONFIG && PGM_ADDR[2:0] == `PFA_CFG_ADDR;
                uid_we = PGM_SPACE == SP_CONFIG && PGM_ADDR[2] == 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            state_r <= ST_IDLE;
            key_r <= KEY_NONE;
            timer_r <= 16'h0;
            op_addr_r <= '0;
            op_erase_r <= 1'b0;
            err_r <= 1'b0;
            done_r <= 1'b0;
            rd_r <= 1'b0;
            hi_r <= 6'h0;
            lo_r <= 8'h0;
            fetch_r <= 14'h0;
            ptr_r <= 14'h0;
            pvld_r <= 1'b0;
            prd_r <= 14'h0;
            ack_r <= 1'b0;
            ref_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            key_r <= key_nxt;
            timer_r <= timer_nxt;
            op_addr_r <= op_addr_nxt;
            op_erase_r <= op_erase_nxt;
            err_r <= err_nxt;
            done_r <= done_nxt;
            rd_r <= rd_nxt;
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
            fetch_r <= fetch_nxt;
            ptr_r <= ptr_nxt;
            pvld_r <= pvld_nxt;
            prd_r <= prd_nxt;
            ack_r <= ack_nxt;
            ref_r <= ref_nxt;
        end
    end

    // Only enabled writes land here; protected requests never raise an enable.
    always_ff @(posedge SYS_CLK)
    begin
        if (bulk)
        begin
            for (int i = 0; i < DEPTH; i++)
                flash_mem[i] <= `PFA_ERASED_WORD;
            for (int i = 0; i < `PFA_EE_DEPTH; i++)
                ee_mem[i] <= `PFA_ERASED_BYTE;
            for (int i = 0; i < `PFA_UID_WORDS; i++)
                uid_mem[i] <= `PFA_ERASED_WORD;
            cfg_r <= `PFA_CFG_ERASED;
        end
        else
        begin
            if (fl_we)
                flash_mem[PGM_ADDR] <= fl_wdata;
            if (ee_we)
                ee_mem[PGM_ADDR[7:0]] <= PGM_WDATA[7:0];
            if (uid_we)
                uid_mem[PGM_ADDR[1:0]] <= uid_mem[PGM_ADDR[1:0]] & PGM_WDATA;
            if (cfg_we)
                cfg_r <= cfg_r & PGM_WDATA[3:0];
            for (int i = 0; i < RW; i++)
            begin
                if (row_erase)
                    flash_mem[{op_addr_r[AW-1:`PFA_ROW_BITS], 6'(i)}] <= `PFA_ERASED_WORD;
                // Unloaded latches leave their words alone.
                if (row_commit && latch_vld_r[i])
                    flash_mem[{op_addr_r[AW-1:`PFA_ROW_BITS], 6'(i)}] <=
                        flash_mem[{op_addr_r[AW-1:`PFA_ROW_BITS], 6'(i)}] & latch_mem[i];
            end
        end
        if (lat_clr)
            latch_vld_r <= '0;
        else if (lat_we)
        begin
            latch_mem[NV_ADDR[`PFA_ROW_BITS-1:0]] <= {hi_r, lo_r};
            latch_vld_r[NV_ADDR[`PFA_ROW_BITS-1:0]] <= 1'b1;
        end
        if (SYS_RST)
            latch_vld_r <= '0;
    end

    assign FETCH_DATA = fetch_r;
    assign PTR_DATA = ptr_r;
    assign PTR_VALID = pvld_r;
    assign NV_DATA_HIGH = hi_r;
    assign NV_DATA_LOW = lo_r;
    assign RD_BUSY = rd_r;
    assign WR_BUSY = state_r[1];
    assign WR_ERROR = err_r;
    assign WR_DONE = done_r;
    assign PGM_RDATA = prd_r;
    assign PGM_ACK = ack_r;
    assign PGM_REFUSED = ref_r;

    logic [15:0] busy_cnt_r;
    always_ff @(posedge SYS_CLK)
        busy_cnt_r <= (SYS_RST || state_r != ST_BUSY) ? 16'h0 : busy_cnt_r + 16'h1;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    prog_timer_len_a: assert property (fin |-> busy_cnt_r == PROG_CYCLES - 16'h1)
        else $error("write timer length wrong");
    cp_refuse_a: assert property (PGM_REQ && state_r == ST_IDLE && PGM_OP == PGM_READ
        && PGM_SPACE == SP_FLASH && cp_on |=> PGM_REFUSED && !PGM_ACK)
        else $error("protected programmer read not refused");
    self_write_cp_a: assert property (wr_go && !wr_prot && (ERASE_SEL || !LATCH_ONLY)
        && cp_on
        |=> WR_BUSY && !WR_ERROR)
        else $error("self erase blocked by code protection");
    bulk_clear_a: assert property (bulk |=> cfg_r == `PFA_CFG_ERASED ##1 PGM_ACK == 1'b0)
        else $error("bulk erase left configuration set");
    wrt_block_a: assert property (wr_go && wr_prot |=> WR_ERROR && WR_DONE && !WR_BUSY
        ##1 !WR_DONE)
        else $error("protected self write not refused");
    pgm_wrt_free_a: assert property (PGM_REQ && state_r == ST_IDLE && PGM_OP == PGM_WRITE
        && PGM_SPACE == SP_FLASH && !cp_on |=> PGM_ACK && !PGM_REFUSED)
        else $error("programmer write refused without code protection");
    read_start_a: assert property (RD_SET && state_r == ST_IDLE |=> RD_BUSY ##1 !RD_BUSY)
        else $error("read start bit not self clearing");
    ptr_one_word_a: assert property (PTR_RD && !$past(PTR_RD) |=> PTR_VALID
        && PTR_DATA == $past(flash_mem[PTR_ADDR]))
        else $error("indirect read word wrong");
    erase_row_a: assert property (fin && op_erase_r |=>
        flash_mem[$past(op_addr_r)] == `PFA_ERASED_WORD)
        else $error("erased word not all ones");

    cov_row_erase_c: cover property (fin && op_erase_r);
    cov_row_commit_c: cover property (fin && !op_erase_r && latch_vld_r != '0);
    cov_pgm_refused_c: cover property (PGM_REFUSED);
    cov_bulk_c: cover property (bulk);
endmodule // pfa_ctrl
`default_nettype wire

// ===== testbench/pfa_sw_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfa_sw_model
    import pfa_pkg::*;
(
    input wire logic clk, // System clock.
    output logic pgm_req, // Programmer strobe.
    output pfa_pgm_op_t pgm_op, // Programmer operation.
    output pfa_space_t pgm_space, // Programmer space.
    output logic [12:0] pgm_addr, // Programmer address.
    output logic [13:0] pgm_wdata, // Programmer data.
    input wire logic [13:0] pgm_rdata, // Programmer read data.
    input wire logic pgm_ack, // Served pulse.
    input wire logic pgm_refused, // Refused pulse.
    output logic [12:0] nv_addr, // Register address.
    output logic nv_hi_we, // Data high strobe.
    output logic nv_lo_we, // Data low strobe.
    output logic [7:0] nv_wdata, // Data pair byte.
    output logic unlock_we, // Key strobe.
    output logic [7:0] unlock_wdata, // Key value.
    output logic rd_set, // Read start.
    output logic wr_set, // Write start.
    output logic wr_enable, // Write enable.
    output logic erase_sel, // Row erase select.
    output logic latch_only, // Latch load only.
    input wire logic rd_busy, // Read start bit.
    input wire logic [5:0] nv_hi, // Data pair high.
    input wire logic [7:0] nv_lo // Data pair low.
);
    initial
    begin
        {pgm_req, pgm_addr, pgm_wdata, nv_addr, nv_hi_we, nv_lo_we, nv_wdata} = '0;
        {unlock_we, unlock_wdata, rd_set, wr_set, wr_enable, erase_sel, latch_only} = '0;
        pgm_op = PGM_READ;
        pgm_space = SP_FLASH;
    end

    // Released data lines show the inverse of the last value.
    task automatic pgm(input pfa_pgm_op_t op, input pfa_space_t sp, input logic [12:0] a,
                       input logic [13:0] d, output logic [13:0] rd, output logic ack,
                       output logic rf);
        @(negedge clk);
        pgm_req = 1'b1;
        pgm_op = op;
        pgm_space = sp;
        pgm_addr = a;
        pgm_wdata = d;
        @(negedge clk);
        pgm_req = 1'b0;
        pgm_wdata = ~d;
        rd = pgm_rdata;
        ack = pgm_ack;
        rf = pgm_refused;
    endtask

    task automatic self_op(input logic [12:0] a, input logic [13:0] d, input logic unl,
                           input logic ers, input logic lat);
        @(negedge clk);
        nv_addr = a;
        nv_hi_we = 1'b1;
        nv_wdata = {2'h0, d[13:8]};
        @(negedge clk);
        nv_hi_we = 1'b0;
        nv_lo_we = 1'b1;
        nv_wdata = d[7:0];
        @(negedge clk);
        nv_lo_we = 1'b0;
        nv_wdata = ~d[7:0];
        unlock_we = unl;
        unlock_wdata = 8'h55;
        @(negedge clk);
        unlock_wdata = 8'haa;
        @(negedge clk);
        unlock_we = 1'b0;
        wr_set = 1'b1;
        wr_enable = 1'b1;
        erase_sel = ers;
        latch_only = lat;
        @(negedge clk);
        wr_set = 1'b0;
    endtask

    task automatic nv_read(input logic [12:0] a, output logic b1, output logic b2,
                           output logic [13:0] w);
        @(negedge clk);
        nv_addr = a;
        rd_set = 1'b1;
        @(negedge clk);
        rd_set = 1'b0;
        b1 = rd_busy;
        @(negedge clk);
        b2 = rd_busy;
        w = {nv_hi, nv_lo};
    endtask
endmodule // pfa_sw_model
`default_nettype wire

// ===== testbench/program_flash_access_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module program_flash_access_control_tb
    import pfa_pkg::*;
;
    localparam int CYC = 10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [12:0] f_addr = '0;
    logic [12:0] p_addr = '0;
    logic p_rd = 1'b0;
    logic [13:0] f_data, p_data, g_wd, g_rd, rd;
    logic p_val, g_req, g_ack, g_ref, n_hwe, n_lwe, u_we, rs, ws, we, es, lo, rb, wb, werr, wd;
    logic b1, b2, ack, rf;
    pfa_pgm_op_t g_op;
    pfa_space_t g_sp;
    logic [12:0] g_a, n_a;
    logic [7:0] n_wd, u_wd, n_lo;
    logic [5:0] n_hi;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;

    always #2 clk = ~clk;

    pfa_ctrl #(.AW(13), .PROG_TIME_NS(CYC * 4)) dut (.SYS_CLK(clk), .SYS_RST(rst),
        .FETCH_ADDR(f_addr), .FETCH_DATA(f_data), .PTR_RD(p_rd), .PTR_ADDR(p_addr),
        .PTR_DATA(p_data), .PTR_VALID(p_val), .NV_ADDR(n_a), .NV_DATA_HIGH_WE(n_hwe),
        .NV_DATA_LOW_WE(n_lwe), .NV_WDATA(n_wd), .NV_DATA_HIGH(n_hi), .NV_DATA_LOW(n_lo),
        .UNLOCK_WE(u_we), .UNLOCK_WDATA(u_wd), .RD_SET(rs), .WR_SET(ws), .WR_ENABLE(we),
        .ERASE_SEL(es), .LATCH_ONLY(lo), .RD_BUSY(rb), .WR_BUSY(wb), .WR_ERROR(werr),
        .WR_DONE(wd), .PGM_REQ(g_req), .PGM_OP(g_op), .PGM_SPACE(g_sp), .PGM_ADDR(g_a),
        .PGM_WDATA(g_wd), .PGM_RDATA(g_rd), .PGM_ACK(g_ack), .PGM_REFUSED(g_ref));

    pfa_sw_model u_sw (.clk(clk), .pgm_req(g_req), .pgm_op(g_op), .pgm_space(g_sp),
        .pgm_addr(g_a), .pgm_wdata(g_wd), .pgm_rdata(g_rd), .pgm_ack(g_ack),
        .pgm_refused(g_ref), .nv_addr(n_a), .nv_hi_we(n_hwe), .nv_lo_we(n_lwe),
        .nv_wdata(n_wd), .unlock_we(u_we), .unlock_wdata(u_wd), .rd_set(rs), .wr_set(ws),
        .wr_enable(we), .erase_sel(es), .latch_only(lo), .rd_busy(rb), .nv_hi(n_hi),
        .nv_lo(n_lo));

    task automatic final_report();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt = error_cnt + 1;
            final_report();
        end
    end

    task automatic chk_w(input string n, input logic [13:0] e, input logic [13:0] g);
        compares = compares + 1;
        if (g !== e)
        begin
            error_cnt = error_cnt + 1;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_b(input string n, input logic e, input logic g);
        compares = compares + 1;
        if (g !== e)
        begin
            error_cnt = error_cnt + 1;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic pchk(input pfa_pgm_op_t op, input pfa_space_t sp, input logic [12:0] a,
                        input logic [13:0] d, input logic ea, input logic [13:0] er);
        u_sw.pgm(op, sp, a, d, rd, ack, rf);
        chk_b("pgm_ack", ea, ack);
        chk_b("pgm_refused", !ea, rf);
        if (op == PGM_READ && ea)
            chk_w("pgm_rdata", er, rd);
    endtask

    task automatic fetch_chk(input logic [12:0] a, input logic [13:0] e);
        @(negedge clk);
        f_addr = a;
        p_addr = a;
        p_rd = 1'b1;
        @(negedge clk);
        p_rd = 1'b0;
        chk_w("fetch_data", e, f_data);
        chk_w("ptr_data", e, p_data);
        chk_b("ptr_valid", 1'b1, p_val);
    endtask

    task automatic wr_chk(input logic [12:0] a, input logic [13:0] d, input logic unl,
                          input logic ers, input logic lat, input logic e_err,
                          input logic timed, input logic e_done);
        u_sw.self_op(a, d, unl, ers, lat);
        chk_b("wr_error", e_err, werr);
        chk_b("wr_busy", timed, wb);
        if (timed)
        begin
            // The timed operation holds the busy bit for exactly CYC cycles.
            repeat (CYC - 1) @(negedge clk);
            chk_b("wr_busy_late", 1'b1, wb);
            @(negedge clk);
        end
        chk_b("wr_done", e_done, wd);
        repeat (2) @(negedge clk);
        chk_b("wr_busy_end", 1'b0, wb);
    endtask

    task automatic t_bulk();
        pchk(PGM_BULK, SP_FLASH, 13'h0000, 14'h0000, 1'b1, 14'h0000);
        pchk(PGM_READ, SP_FLASH, 13'h0000, 14'h0000, 1'b1, 14'h3fff);
        pchk(PGM_READ, SP_CONFIG, 13'h0004, 14'h0000, 1'b1, 14'h000f);
        pchk(PGM_WRITE, SP_EEPROM, 13'h0010, 14'h0055, 1'b1, 14'h0000);
        pchk(PGM_READ, SP_EEPROM, 13'h0010, 14'h0000, 1'b1, 14'h0055);
    endtask

    task automatic t_prog_and();
        pchk(PGM_WRITE, SP_FLASH, 13'h0000, 14'h0f0f, 1'b1, 14'h0000);
        pchk(PGM_WRITE, SP_FLASH, 13'h0000, 14'h3ff0, 1'b1, 14'h0000);
        pchk(PGM_READ, SP_FLASH, 13'h0000, 14'h0000, 1'b1, 14'h0f00);
        fetch_chk(13'h0000, 14'h0f00);
        fetch_chk(13'h1fff, 14'h3fff);
    endtask

    task automatic t_reg_read();
        u_sw.nv_read(13'h0000, b1, b2, rd);
        chk_b("rd_busy_first", 1'b1, b1);
        chk_b("rd_busy_second", 1'b0, b2);
        chk_w("nv_data_pair", 14'h0f00, rd);
    endtask

    task automatic t_self_write();
        wr_chk(13'h0041, 14'h1555, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        wr_chk(13'h0043, 14'h2aaa, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        fetch_chk(13'h0041, 14'h1555);
        fetch_chk(13'h0043, 14'h2aaa);
        fetch_chk(13'h0042, 14'h3fff);
        wr_chk(13'h0042, 14'h0777, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        fetch_chk(13'h0042, 14'h0777);
        fetch_chk(13'h0041, 14'h1555);
        wr_chk(13'h0044, 14'h0000, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        fetch_chk(13'h0044, 14'h3fff);
    endtask

    task automatic t_erase_row();
        u_sw.nv_read(13'h0041, b1, b2, rd);
        chk_w("nv_data_keep", 14'h1555, rd);
        wr_chk(13'h0043, 14'h0000, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        fetch_chk(13'h0041, 14'h3fff);
        fetch_chk(13'h0042, 14'h3fff);
        fetch_chk(13'h0000, 14'h0f00);
        // Retained word goes back into its latch, then the new word commits the row.
        wr_chk(13'h0041, rd, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        wr_chk(13'h0042, 14'h0555, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        fetch_chk(13'h0041, 14'h1555);
        fetch_chk(13'h0042, 14'h0555);
    endtask

    task automatic t_wrt();
        pchk(PGM_WRITE, SP_CONFIG, 13'h0004, 14'h0003, 1'b1, 14'h0000);
        wr_chk(13'h0044, 14'h0000, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        fetch_chk(13'h0044, 14'h3fff);
        pchk(PGM_WRITE, SP_FLASH, 13'h0044, 14'h0123, 1'b1, 14'h0000);
        pchk(PGM_READ, SP_FLASH, 13'h0044, 14'h0000, 1'b1, 14'h0123);
    endtask

    task automatic t_cp();
        pchk(PGM_BULK, SP_FLASH, 13'h0000, 14'h0000, 1'b1, 14'h0000);
        pchk(PGM_WRITE, SP_CONFIG, 13'h0004, 14'h000c, 1'b1, 14'h0000);
        pchk(PGM_READ, SP_FLASH, 13'h0000, 14'h0000, 1'b0, 14'h0000);
        pchk(PGM_WRITE, SP_EEPROM, 13'h0010, 14'h0011, 1'b0, 14'h0000);
        pchk(PGM_READ, SP_CONFIG, 13'h0004, 14'h0000, 1'b1, 14'h000c);
        wr_chk(13'h0080, 14'h1111, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        fetch_chk(13'h0080, 14'h1111);
        pchk(PGM_BULK, SP_FLASH, 13'h0000, 14'h0000, 1'b1, 14'h0000);
        pchk(PGM_READ, SP_CONFIG, 13'h0004, 14'h0000, 1'b1, 14'h000f);
        pchk(PGM_READ, SP_FLASH, 13'h0080, 14'h0000, 1'b1, 14'h3fff);
    endtask

    initial
    begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_bulk();
        t_prog_and();
        t_reg_read();
        t_self_write();
        t_erase_row();
        t_wrt();
        t_cp();
        final_report();
    end
endmodule // program_flash_access_control_tb
`default_nettype wire
